// [design/csu_pkg.sv]
// Purpose: Shared constants and types of the clock synthesis unit
// Assumes: 16-bit register words on a plain strobe port
// Notes: Offsets are word indices on the register port
package csu_pkg;

  // ==========================================================
  // Register port
  localparam int CSU_AW = 3;
  localparam int CSU_DW = 16;

  typedef struct packed {
    logic [CSU_AW-1:0] addr;
    logic [CSU_DW-1:0] wdata;
    logic wr;
    logic rd;
  } csu_bus_t;

  // ==========================================================
  // Register offsets
  localparam logic [CSU_AW-1:0] CSU_OFS_CTRL = 3'h0;
  localparam logic [CSU_AW-1:0] CSU_OFS_DIVBY = 3'h1;
  localparam logic [CSU_AW-1:0] CSU_OFS_STAT = 3'h2;
  localparam logic [CSU_AW-1:0] CSU_OFS_SHUTDN = 3'h3;
  localparam logic [CSU_AW-1:0] CSU_OFS_OCTRL = 3'h4;
  localparam logic [CSU_AW-1:0] CSU_OFS_FOPT = 3'h5;

  // ==========================================================
  // Field positions
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_PLL_PD_BIT = 1;
  localparam int CTRL_PLL_SEL_BIT = 2;
  localparam int DIVBY_POST_LSB = 0;
  localparam int DIVBY_POST_W = 3;
  localparam int STAT_LOR_BIT = 0;
  localparam int STAT_SRC_BIT = 1;
  localparam int STAT_PLL_BIT = 2;
  localparam int STAT_PEND_BIT = 3;
  localparam int STAT_SHUT_BIT = 4;
  localparam int SHUTDN_EN_BIT = 0;
  localparam int OCTRL_TRIM_LSB = 0;
  localparam int OCTRL_TRIM_W = 10;
  localparam int OCTRL_XTAL_PD_BIT = 12;
  localparam int OCTRL_RELAX_STBY_BIT = 13;
  localparam int OCTRL_RELAX_PD_BIT = 14;

  // ==========================================================
  // Reset values
  localparam logic [CSU_DW-1:0] CTRL_RST = 16'h0002;
  localparam logic [CSU_DW-1:0] DIVBY_RST = 16'h0000;
  localparam logic [CSU_DW-1:0] SHUTDN_RST = 16'h0000;
  localparam logic [CSU_DW-1:0] OCTRL_RST = 16'h0000;

  // ==========================================================
  // Frequencies and timing
  localparam int CLK_MHZ = 50;
  localparam int FOUT_MAX_MHZ = 32;
  localparam int PLL_MULT = 8;
  localparam int XTAL_MIN_MHZ = 4;
  localparam int XTAL_MAX_MHZ = 8;
  localparam int RELAX_NOM_KHZ = 8000;
  localparam int TRIM_STEP_PPM = 780;
  localparam int LOR_TIME_NS = 2000;
  localparam int LOR_CYC = (LOR_TIME_NS * CLK_MHZ) / 1000;
  localparam int LOR_CW = 12;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_SHUT = 3'b100
  } csu_sw_state_t;

  typedef struct packed {
    logic relax_pd;
    logic relax_stby;
    logic xtal_pd;
    logic pll_pd;
    logic [OCTRL_TRIM_W-1:0] trim;
  } csu_osc_ctl_t;

  typedef struct packed {
    logic clk2x_en;
    logic sys_en;
    logic sys_clk_lvl;
    logic clk3x_en;
  } csu_clk_en_t;

endpackage

// [design/csu_sync_edge.sv]
// Purpose: Two-stage synchroniser with rising-edge pulse
// Assumes: Input is asynchronous to clk
// Notes: Pulse is one clk cycle, from a flip-flop
`timescale 1ns/1ps
module csu_sync_edge
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ==========================================================
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise <= sync_r & ~prev_r;
    end
  end

endmodule

// [design/csu_top.sv]
// Purpose: Clock synthesis control: source select, PLL path, postscaler, enables
// Assumes: Oscillator and PLL outputs arrive as pins sampled at 50 MHz
// Notes: Output clocks are one-cycle enables of clk plus a system clock level, not real clocks
//
// Overview of operation
// - Software picks output rate, up to 32MHz
// - Three-bit postscaler divides PLL output
// - Provide 2X clock to system integration unit
// - Provide 3X clock to PWM and timers
// - Safety shutdown on lost PLL reference
// - Bypass: 2X equals oscillator rate
// - PLL: 2X is oscillator times eight over postscaler
// - System clock is 2X halved, 50% duty
// - Reset selects relaxation oscillator, select bit zero
// - Software may switch external, power internal down
// - Ten-bit trim field in bits 0-9
// - Each trim step about 0.078% of 8MHz
// - Factory trim copied to flash option word
// - Relaxation oscillator has a standby state
// - Either oscillator powers down independently
// - Software may power down the PLL
// - Crystal reference 4 to 8MHz
`timescale 1ns/1ps
module csu_top
  import csu_pkg::*;
#(
  parameter int LOR_CYCLES = LOR_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire csu_bus_t bus,
  output logic [CSU_DW-1:0] rd_data,
  input wire logic relax_osc_in,
  input wire logic xtal_osc_in,
  input wire logic pll_out_in,
  input wire logic [OCTRL_TRIM_W-1:0] factory_trim,
  output csu_osc_ctl_t osc_ctl,
  output csu_clk_en_t clk_en,
  output logic shutdown_active
);

  // ==========================================================
  // Declarations
  logic [CSU_DW-1:0] ctrl_r;
  logic [CSU_DW-1:0] divby_r;
  logic [CSU_DW-1:0] shutdn_r;
  logic [CSU_DW-1:0] octrl_r;
  logic [OCTRL_TRIM_W-1:0] fopt_r;
  logic fopt_done_r;
  logic lor_r;
  logic [CSU_DW-1:0] rd_nxt;
  logic [2:0] edge_in;
  logic [2:0] edge_tick;
  logic relax_tick;
  logic xtal_tick;
  logic pll_tick;
  csu_sw_state_t sw_r;
  logic src_r;
  logic src_req;
  logic ref_tick;
  logic [LOR_CW-1:0] lor_cnt_r;
  logic lor_hit;
  logic use_pll;
  logic [4:0] post_cnt_r;
  logic [4:0] post_lim;
  logic post_tick;
  logic base_tick;
  logic half_r;
  logic [2:0] credit_r;
  logic [2:0] credit_nxt;
  logic wr_ctrl;
  logic wr_divby;
  logic wr_stat;
  logic wr_shutdn;
  logic wr_octrl;

  // ==========================================================
  // Helpers
  // Postscaler code to terminal count (divisor minus one)
  function automatic logic [4:0] post_limit(input logic [DIVBY_POST_W-1:0] code);
    case (code)
      3'h0: post_limit = 5'h00;
      3'h1: post_limit = 5'h01;
      3'h2: post_limit = 5'h03;
      3'h3: post_limit = 5'h07;
      3'h4: post_limit = 5'h0f;
      default: post_limit = 5'h1f;
    endcase
  endfunction

  function automatic logic hit(input logic [CSU_AW-1:0] a, input logic [CSU_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // Pin synchronisers
  assign edge_in = {pll_out_in, xtal_osc_in, relax_osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      csu_sync_edge u_sync
      (
        .clk(clk),
        .resetn(resetn),
        .din(edge_in[gi]),
        .rise(edge_tick[gi])
      );
    end
  endgenerate

  assign relax_tick = edge_tick[0];
  assign xtal_tick = edge_tick[1];
  assign pll_tick = edge_tick[2];

  // ==========================================================
  // Register write decode
  assign wr_ctrl = bus.wr && hit(bus.addr, CSU_OFS_CTRL);
  assign wr_divby = bus.wr && hit(bus.addr, CSU_OFS_DIVBY);
  assign wr_stat = bus.wr && hit(bus.addr, CSU_OFS_STAT);
  assign wr_shutdn = bus.wr && hit(bus.addr, CSU_OFS_SHUTDN);
  assign wr_octrl = bus.wr && hit(bus.addr, CSU_OFS_OCTRL);

  // Reference select, PLL enable and power-down word
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= bus.wdata;
  end

  // Postscaler code
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      divby_r <= DIVBY_RST;
    else if (wr_divby)
      divby_r <= {13'h0000, bus.wdata[DIVBY_POST_LSB +: DIVBY_POST_W]};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      shutdn_r <= SHUTDN_RST;
    else if (wr_shutdn)
      shutdn_r <= {15'h0000, bus.wdata[SHUTDN_EN_BIT]};
  end

  // Trim and oscillator power controls
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      octrl_r <= OCTRL_RST;
    else if (wr_octrl)
      octrl_r <= bus.wdata;
  end

  // ==========================================================
  // Factory trim capture, one clock after reset release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fopt_r <= '0;
      fopt_done_r <= 1'b0;
    end
    else if (!fopt_done_r)
    begin
      fopt_r <= factory_trim;
      fopt_done_r <= 1'b1;
    end
  end

  // ==========================================================
  // Source switch; a requested source takes over only on its own edge, while shutdown forces the internal one at once
  assign src_req = ctrl_r[CTRL_SRC_BIT];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sw_r <= SW_IDLE;
      src_r <= 1'b0;
    end
    else
    begin
      case (sw_r)
        SW_IDLE:
        begin
          if (lor_hit && shutdn_r[SHUTDN_EN_BIT])
            sw_r <= SW_SHUT;
          else if (src_req != src_r)
            sw_r <= SW_WAIT;
        end
        SW_WAIT:
        begin
          if (lor_hit && shutdn_r[SHUTDN_EN_BIT])
            sw_r <= SW_SHUT;
          else if (src_req == src_r)
            sw_r <= SW_IDLE;
          else if (src_req ? xtal_tick : relax_tick)
          begin
            // Old source stops, new one starts at its own edge
            src_r <= src_req;
            sw_r <= SW_IDLE;
          end
        end
        SW_SHUT:
        begin
          // Held on the internal oscillator until software clears the flag
          src_r <= 1'b0;
          if (!lor_r)
            sw_r <= SW_IDLE;
        end
        default: sw_r <= SW_IDLE;
      endcase
    end
  end

  assign ref_tick = src_r ? xtal_tick : relax_tick;

  // ==========================================================
  // Loss-of-reference watchdog
  assign lor_hit = (lor_cnt_r >= LOR_CYCLES[LOR_CW-1:0]);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lor_cnt_r <= '0;
    else if (ref_tick || sw_r != SW_IDLE)
      lor_cnt_r <= '0;
    else if (!lor_hit)
      lor_cnt_r <= lor_cnt_r + 1'b1;
  end

  // Sticky; a new loss wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lor_r <= 1'b0;
    else if (lor_hit)
      lor_r <= 1'b1;
    else if (wr_stat && bus.wdata[STAT_LOR_BIT])
      lor_r <= 1'b0;
  end

  // ==========================================================
  // PLL path and postscaler
  assign use_pll = ctrl_r[CTRL_PLL_SEL_BIT] && !ctrl_r[CTRL_PLL_PD_BIT] && sw_r != SW_SHUT;
  assign post_lim = post_limit(divby_r[DIVBY_POST_LSB +: DIVBY_POST_W]);
  assign post_tick = pll_tick && (post_cnt_r >= post_lim);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      post_cnt_r <= '0;
    else if (!use_pll)
      post_cnt_r <= '0;
    else if (pll_tick)
      post_cnt_r <= (post_cnt_r >= post_lim) ? 5'h00 : post_cnt_r + 5'h01;
  end

  // Rate is set by source, PLL select and postscaler; fastest code 0 passes every PLL edge undivided
  assign base_tick = use_pll ? post_tick : ref_tick;

  // ==========================================================
  // Clock enables
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      half_r <= 1'b0;
    else if (base_tick)
      half_r <= ~half_r;
  end

  // 3X from 2X: three credits per 2X pulse when at most four remain after spending, one spent per cycle
  always_comb
  begin
    credit_nxt = credit_r;
    if (credit_r != 3'h0)
      credit_nxt = credit_nxt - 3'h1;
    if (base_tick && credit_nxt <= 3'h4)
      credit_nxt = credit_nxt + 3'h3;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      credit_r <= '0;
    else
      credit_r <= credit_nxt;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      clk_en <= '0;
    else
    begin
      clk_en.clk2x_en <= base_tick;
      clk_en.sys_en <= base_tick && half_r;
      clk_en.sys_clk_lvl <= half_r;
      clk_en.clk3x_en <= (credit_r != 3'h0);
    end
  end

  // ==========================================================
  // Analog controls; shutdown forces the internal oscillator awake
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_ctl <= '0;
      osc_ctl.pll_pd <= CTRL_RST[CTRL_PLL_PD_BIT];
      shutdown_active <= 1'b0;
    end
    else
    begin
      osc_ctl.relax_pd <= octrl_r[OCTRL_RELAX_PD_BIT] && sw_r != SW_SHUT;
      osc_ctl.relax_stby <= octrl_r[OCTRL_RELAX_STBY_BIT] && sw_r != SW_SHUT;
      osc_ctl.xtal_pd <= octrl_r[OCTRL_XTAL_PD_BIT];
      osc_ctl.pll_pd <= ctrl_r[CTRL_PLL_PD_BIT] || sw_r == SW_SHUT;
      osc_ctl.trim <= octrl_r[OCTRL_TRIM_LSB +: OCTRL_TRIM_W];
      shutdown_active <= (sw_r == SW_SHUT);
    end
  end

  // ==========================================================
  // Read path; unmapped offsets read zero
  always_comb
  begin
    rd_nxt = '0;
    case (bus.addr)
      CSU_OFS_CTRL: rd_nxt = ctrl_r;
      CSU_OFS_DIVBY: rd_nxt = divby_r;
      CSU_OFS_STAT:
      begin
        rd_nxt[STAT_LOR_BIT] = lor_r;
        rd_nxt[STAT_SRC_BIT] = src_r;
        rd_nxt[STAT_PLL_BIT] = use_pll;
        rd_nxt[STAT_PEND_BIT] = (sw_r == SW_WAIT);
        rd_nxt[STAT_SHUT_BIT] = (sw_r == SW_SHUT);
      end
      CSU_OFS_SHUTDN: rd_nxt = shutdn_r;
      CSU_OFS_OCTRL: rd_nxt = octrl_r;
      CSU_OFS_FOPT: rd_nxt[OCTRL_TRIM_W-1:0] = fopt_r;
      default: rd_nxt = '0;
    endcase
  end

  // Holds last value when no read; only the cycle after a read is valid
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rd_data <= '0;
    else if (bus.rd)
      rd_data <= rd_nxt;
  end

endmodule

// [bench/csu_checker.sv]
// Purpose: Port-level assertions for csu_top
// Assumes: Single clock domain, resetn async active low
// Notes: Attached by bind below the module
`timescale 1ns/1ps
module csu_checker
  import csu_pkg::*;
#(
  parameter int LOR_CYCLES = LOR_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire csu_bus_t bus,
  input wire logic [CSU_DW-1:0] rd_data,
  input wire logic [OCTRL_TRIM_W-1:0] factory_trim,
  input wire csu_osc_ctl_t osc_ctl,
  input wire csu_clk_en_t clk_en,
  input wire logic shutdown_active
);
  // ==========================================
  // Helpers
  logic half_r;
  logic signed [7:0] cred_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      half_r <= 1'b0;
    else if (clk_en.clk2x_en)
      half_r <= ~half_r;
  end
  // Credits: three per 2X pulse, one spent per 3X pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cred_r <= 8'sh00;
    else
      cred_r <= cred_r + (clk_en.clk2x_en ? 8'sh03 : 8'sh00) - (clk_en.clk3x_en ? 8'sh01 : 8'sh00);
  end
  // ==========================================
  // Sequences
  sequence s_oct_wr;
    bus.wr && bus.addr == CSU_OFS_OCTRL;
  endsequence
  sequence s_ctl_wr;
    bus.wr && bus.addr == CSU_OFS_CTRL;
  endsequence
  // ==========================================
  // Assertions
  a_reset_pll_down: assert property (!$past(resetn)
    |-> osc_ctl.pll_pd && !osc_ctl.relax_pd)
    else $error("reset output state wrong");
  a_sys_half_rate: assert property (clk_en.clk2x_en |-> clk_en.sys_en == half_r)
    else $error("sys enable not every second 2X pulse");
  a_lvl_holds: assert property (!clk_en.clk2x_en && !$past(clk_en.clk2x_en)
    |-> $stable(clk_en.sys_clk_lvl))
    else $error("system level moved without 2X pulse");
  // A stuck level would pass the check above, so tie it to the pulse count too
  a_lvl_follows: assert property (clk_en.clk2x_en |=> clk_en.sys_clk_lvl == half_r)
    else $error("system level did not toggle with 2X pulse");
  a_three_x_credit: assert property (cred_r >= 8'sh00 && cred_r <= 8'sh06)
    else $error("3X pulses out of step with 2X");
  a_no_short_pulse: assert property (clk_en.clk2x_en |=> !clk_en.clk2x_en)
    else $error("2X pulses back to back");
  a_unmapped_zero: assert property (bus.rd && bus.addr > CSU_OFS_FOPT
    |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  a_fopt_trim: assert property (bus.rd && bus.addr == CSU_OFS_FOPT && $past(resetn)
    |=> rd_data == {6'h00, $past(factory_trim)})
    else $error("flash option word wrong");
  a_shut_forces: assert property ($rose(shutdown_active) |-> ##[0:2]
    (osc_ctl.pll_pd && !osc_ctl.relax_pd && !osc_ctl.relax_stby))
    else $error("shutdown did not force safe sources");
  a_trim_write: assert property (s_oct_wr |-> ##2
    osc_ctl.trim == $past(bus.wdata[9:0], 2))
    else $error("trim not taken from write");
  a_pll_pd_write: assert property (s_ctl_wr |-> ##2
    (shutdown_active || osc_ctl.pll_pd == $past(bus.wdata[CTRL_PLL_PD_BIT], 2)))
    else $error("PLL power down not taken from write");
endmodule

bind csu_top csu_checker #(.LOR_CYCLES(LOR_CYCLES)) u_chk (.clk(clk), .resetn(resetn),
  .bus(bus), .rd_data(rd_data), .factory_trim(factory_trim), .osc_ctl(osc_ctl),
  .clk_en(clk_en), .shutdown_active(shutdown_active));

// [bench/csu_top_tb.sv]
// Purpose: Self-checking bench for csu_top
// Assumes: Pins toggled on clk edges at fixed ratios
// Notes: Short loss time so the safety path runs quickly
`timescale 1ns/1ps
module csu_top_tb;
  import csu_pkg::*;
  localparam logic [9:0] FTRIM = 10'h2a5;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  csu_bus_t bus = '0;
  logic [CSU_DW-1:0] rd_data;
  logic relax = 1'b0;
  logic xtal = 1'b0;
  logic pll = 1'b0;
  logic [2:0] run = 3'b011;
  csu_osc_ctl_t osc_ctl;
  csu_clk_en_t clk_en;
  logic shutdown_active;
  int fail_count = 0;
  int comparisons = 0;
  int ph = 0;
  int n2, n3, ns;
  logic [CSU_DW-1:0] v;
  logic [2:0] ofs [8] = '{CSU_OFS_CTRL, CSU_OFS_DIVBY, CSU_OFS_STAT, CSU_OFS_SHUTDN,
    CSU_OFS_OCTRL, CSU_OFS_FOPT, 3'h6, 3'h7};
  logic [15:0] rst [8] = '{CTRL_RST, DIVBY_RST, 16'h0000, SHUTDN_RST, OCTRL_RST,
    {6'h00, FTRIM}, 16'h0000, 16'h0000};

  csu_top #(.LOR_CYCLES(20)) uut (.clk(clk), .resetn(resetn), .bus(bus), .rd_data(rd_data),
    .relax_osc_in(relax), .xtal_osc_in(xtal), .pll_out_in(pll), .factory_trim(FTRIM),
    .osc_ctl(osc_ctl), .clk_en(clk_en), .shutdown_active(shutdown_active));

  initial
  begin
    forever #10 clk = ~clk;
  end
  // ==========================================
  // Pins: stopped pins hold level, so no edges
  always @(posedge clk)
  begin
    ph <= ph + 1;
    if (run[0]) relax <= (ph % 6) < 3;
    if (run[1]) xtal <= (ph % 8) < 4;
    if (run[2]) pll <= (ph % 4) < 2;
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] near(input int s, input int e, input int t);
    return {15'h0000, (s >= e - t) && (s <= e + t)};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic cnt(input int n);
    n2 = 0;
    n3 = 0;
    ns = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (clk_en.clk2x_en === 1'b1) n2++;
      if (clk_en.clk3x_en === 1'b1) n3++;
      if (clk_en.sys_en === 1'b1) ns++;
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Switch must settle; a stuck pending flag ends the run
  task automatic wait_sw;
    int i;
    for (i = 0; i < 40; i++)
    begin
      rd(CSU_OFS_STAT);
      if (v[STAT_PEND_BIT] === 1'b0) break;
    end
    if (i == 40)
    begin
      fail_count++;
      $display("[ERR] %0t source switch stuck", $time);
      test_done;
    end
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t run too long", $time);
    test_done;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(osc_ctl.pll_pd, 16'h1);
    chk(osc_ctl.relax_pd, 16'h0);
    foreach (ofs[i])
    begin
      rd(ofs[i]);
      chk(v, rst[i]);
    end
    wr(CSU_OFS_OCTRL, {6'h00, FTRIM});
    rd(CSU_OFS_OCTRL);
    chk(v, {6'h00, FTRIM});
    chk(osc_ctl.trim, FTRIM);
    wr(CSU_OFS_OCTRL, 16'h3000 | FTRIM);
    chk(osc_ctl.xtal_pd, 16'h1);
    chk(osc_ctl.relax_stby, 16'h1);
    wr(CSU_OFS_OCTRL, {6'h00, FTRIM});
    cnt(600);
    chk(near(n2, 100, 1), 16'h1);
    chk(near(ns, 50, 1), 16'h1);
    chk(near(n3, 300, 3), 16'h1);
    run[2] = 1'b1;
    wr(CSU_OFS_CTRL, 16'h0004);
    chk(osc_ctl.pll_pd, 16'h0);
    for (int k = 0; k < 8; k++)
    begin
      wr(CSU_OFS_DIVBY, 16'(k));
      repeat (200) @(posedge clk);
      cnt(512);
      chk(near(n2, 128 >> (k > 5 ? 5 : k), 1), 16'h1);
    end
    rd(CSU_OFS_STAT);
    chk(v[STAT_PLL_BIT], 16'h1);
    // Crystal has run since reset, so it is stable before the switch
    wr(CSU_OFS_CTRL, 16'h0003);
    wait_sw;
    chk(v[STAT_SRC_BIT], 16'h1);
    cnt(800);
    chk(near(n2, 100, 1), 16'h1);
    wr(CSU_OFS_OCTRL, 16'h4000 | FTRIM);
    chk(osc_ctl.relax_pd, 16'h1);
    chk(osc_ctl.xtal_pd, 16'h0);
    wr(CSU_OFS_SHUTDN, 16'h0001);
    run[1] = 1'b0;
    repeat (60) @(posedge clk);
    #1;
    chk(shutdown_active, 16'h1);
    chk(osc_ctl.relax_pd, 16'h0);
    rd(CSU_OFS_STAT);
    chk(v & 16'h0011, 16'h0011);
    run[1] = 1'b1;
    wr(CSU_OFS_STAT, 16'h0001);
    repeat (40) @(posedge clk);
    #1;
    chk(shutdown_active, 16'h0);
    rd(CSU_OFS_STAT);
    chk(v[STAT_LOR_BIT], 16'h0);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(CSU_OFS_OCTRL);
    chk(v, OCTRL_RST);
    rd(CSU_OFS_CTRL);
    chk(v, CTRL_RST);
    test_done;
  end
endmodule
